// ===== rtl/intr_pkg.sv
// Constants for the event count bus interrupter.
// Assumes a 16-bit register path and a byte-wide status/ID.
package intr_pkg;
	// ---------------------------------------------
	// Register offsets within the board window
	// ---------------------------------------------
	localparam logic [15:0] OFS_IRQ_LEVEL_SELECT = 16'h100A;
	localparam logic [15:0] OFS_IRQ_VECTOR_BYTE = 16'h100C;
	localparam logic [15:0] OFS_EVENT_COUNT_TRIGGER = 16'h1020;
	// ---------------------------------------------
	// Widths and fields
	// ---------------------------------------------
	localparam int DATA_W = 16;
	localparam int ADDR_W = 16;
	localparam int COUNT_W = 16;
	localparam int LEVEL_W = 3;
	localparam int VECTOR_W = 8;
	localparam int LEVEL_LSB = 0;
	localparam int VECTOR_LSB = 0;
	// ---------------------------------------------
	// Reset values
	// ---------------------------------------------
	localparam logic [LEVEL_W-1:0] RST_IRQ_LEVEL = 3'h0;
	localparam logic [VECTOR_W-1:0] RST_IRQ_VECTOR = 8'h00;
	localparam logic [COUNT_W-1:0] RST_EVENT_TRIGGER = 16'h0000;
	// Level value that disables the request
	localparam logic [LEVEL_W-1:0] LEVEL_OFF = 3'h0;
	// Trigger value that disables the request
	localparam logic [COUNT_W-1:0] TRIGGER_OFF = 16'h0000;
	// ---------------------------------------------
	// Types
	// ---------------------------------------------
	typedef enum logic [1:0] {ACK_IDLE, ACK_RESPOND, ACK_PASS} ack_state_t;
	typedef enum logic [1:0] {REG_IDLE, REG_DECODE, REG_ANSWER, REG_RELEASE} reg_state_t;
endpackage

// ===== rtl/pin_sync.sv
// Three-stage input synchroniser for backplane pins.
// Assumes inputs arrive from outside the sys_clk domain.
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Pins in, filtered value out
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_q
);
	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;
	logic [WIDTH-1:0] stage3_q;

	// ---------------------------------------------
	// Capture chain
	// ---------------------------------------------
	// First stage feeds only the second
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stage1_q <= INIT;
			stage2_q <= INIT;
			stage3_q <= INIT;
		end else begin
			stage1_q <= pin_in;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
		end
	end

	// A change counts once stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin_q <= INIT;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2_q[i] == stage3_q[i]) begin
					pin_q[i] <= stage3_q[i];
				end
			end
		end
	end
endmodule // pin_sync

// ===== rtl/iack_responder.sv
// Interrupt acknowledge cycle handler with daisy chain pass-on.
// Assumes synchronised, active-high strobes from the top module.
module iack_responder (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Acknowledge cycle, active high
	input wire logic strobe_as,
	input wire logic strobe_ds,
	input wire logic iack_cycle,
	input wire logic iack_chain_in,
	input wire logic [intr_pkg::LEVEL_W-1:0] ack_level,
	// Local request state
	input wire logic req_pending,
	input wire logic [intr_pkg::LEVEL_W-1:0] req_level,
	// Decision
	output logic respond_q,
	output logic pass_q
);
	import intr_pkg::*;

	ack_state_t state_q;
	ack_state_t state_d;

	// ---------------------------------------------
	// Cycle decision
	// ---------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ACK_IDLE: begin
				if (strobe_as && strobe_ds && iack_cycle && iack_chain_in) begin
					if (req_pending && req_level != LEVEL_OFF && ack_level == req_level) begin
						state_d = ACK_RESPOND;
					end else begin
						state_d = ACK_PASS;
					end
				end
			end
			ACK_RESPOND: begin
				if (!strobe_as || !strobe_ds) begin
					state_d = ACK_IDLE;
				end
			end
			ACK_PASS: begin
				// Chain released by upstream or cycle end
				if (!strobe_as || !iack_chain_in) begin
					state_d = ACK_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= ACK_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			respond_q <= 1'b0;
			pass_q <= 1'b0;
		end else begin
			respond_q <= (state_d == ACK_RESPOND);
			pass_q <= (state_d == ACK_PASS);
		end
	end
endmodule // iack_responder

// ===== rtl/event_count_bus_interrupter.sv
// Release-on-register-access interrupter with its three registers.
// Assumes board address match comes from the local decoder on sys_clk,
// and the event count comes from the event memory logic on sys_clk.

// What this block does
// - Raise the request when stored event count equals the trigger count.
// - Trigger count zero never interrupts; it resets to zero.
// - Answer 8, 16 or 32 bit acknowledges with a byte on D00-D07.
// - Hold request until the count drops below trigger; never drop it on acknowledge.
// - Status/ID byte is the low byte of the vector register.
// - Request level is the low three bits of the level register.
// - Level bits all zero disables interrupt generation entirely.
// - Output buffer reads lowering count below trigger release the request.
// - Configuration registers take 8 and 16-bit transfers; 32-bit ones get a bus error.
module event_count_bus_interrupter #(
	parameter int COUNT_WIDTH = intr_pkg::COUNT_W
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Event memory fill level
	input wire logic [COUNT_WIDTH-1:0] event_count,
	// Backplane cycle pins
	input wire logic addr_hit,
	input wire logic as_n,
	input wire logic [1:0] ds_n,
	input wire logic write_n,
	input wire logic lword_n,
	input wire logic iack_n,
	input wire logic iackin_n,
	input wire logic [intr_pkg::ADDR_W-1:0] addr,
	// Data lines, two-way
	input wire logic [intr_pkg::DATA_W-1:0] data_in,
	output logic [intr_pkg::DATA_W-1:0] data_out,
	output logic [intr_pkg::DATA_W-1:0] data_oe,
	// Cycle answers, open drain except iackout_n
	output logic dtack_n_out,
	output logic dtack_oe,
	output logic berr_n_out,
	output logic berr_oe,
	output logic iackout_n,
	// Interrupt request lines 1 to 7, open drain
	output logic [7:1] irq_n_out,
	output logic [7:1] irq_oe
);
	import intr_pkg::*;

	// ---------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------
	localparam int CTL_W = 7;
	logic [CTL_W-1:0] ctl_pins;
	logic [CTL_W-1:0] ctl_q;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] data_s;
	logic as_s;
	logic ds_s;
	logic wr_s;
	logic d32_s;
	logic iack_s;
	logic iackin_s;

	assign ctl_pins = {as_n, ds_n, write_n, lword_n, iack_n, iackin_n};

	pin_sync #(.WIDTH(CTL_W), .INIT({CTL_W{1'b1}})) u_ctl_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in(ctl_pins),
		.pin_q(ctl_q)
	);

	pin_sync #(.WIDTH(ADDR_W), .INIT({ADDR_W{1'b0}})) u_addr_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in(addr),
		.pin_q(addr_s)
	);

	pin_sync #(.WIDTH(DATA_W), .INIT({DATA_W{1'b0}})) u_data_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in(data_in),
		.pin_q(data_s)
	);

	// Active-high views of the filtered strobes
	assign as_s = !ctl_q[6];
	assign ds_s = !ctl_q[5] || !ctl_q[4];
	assign wr_s = !ctl_q[3];
	assign d32_s = !ctl_q[2];
	assign iack_s = !ctl_q[1];
	assign iackin_s = !ctl_q[0];

	// ---------------------------------------------
	// Configuration registers
	// ---------------------------------------------
	logic [LEVEL_W-1:0] level_q;
	logic [VECTOR_W-1:0] vector_q;
	logic [COUNT_WIDTH-1:0] trigger_q;

	function automatic logic is_mapped(input logic [ADDR_W-1:0] ofs);
		return ofs == OFS_IRQ_LEVEL_SELECT || ofs == OFS_IRQ_VECTOR_BYTE
			|| ofs == OFS_EVENT_COUNT_TRIGGER;
	endfunction

	reg_state_t reg_state_q;
	reg_state_t reg_state_d;
	logic reg_start;
	logic reg_ok;
	logic reg_write;

	// Register cycle only when not an acknowledge
	assign reg_start = as_s && ds_s && !iack_s && addr_hit && is_mapped(addr_s);
	// Any transfer but a 32-bit one reaches the registers
	assign reg_ok = !d32_s;
	assign reg_write = (reg_state_q == REG_DECODE) && reg_ok && wr_s;

	always_comb begin
		reg_state_d = reg_state_q;
		unique case (reg_state_q)
			REG_IDLE: begin
				if (reg_start) begin
					reg_state_d = REG_DECODE;
				end
			end
			REG_DECODE: begin
				reg_state_d = REG_ANSWER;
			end
			REG_ANSWER: begin
				if (!ds_s) begin
					reg_state_d = REG_RELEASE;
				end
			end
			REG_RELEASE: begin
				// Wait for the address strobe too, so one cycle gives one access
				if (!as_s) begin
					reg_state_d = REG_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_state_q <= REG_IDLE;
		end else begin
			reg_state_q <= reg_state_d;
		end
	end

	// Level held in the low three bits
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			level_q <= RST_IRQ_LEVEL;
		end else if (reg_write && addr_s == OFS_IRQ_LEVEL_SELECT) begin
			level_q <= data_s[LEVEL_LSB +: LEVEL_W];
		end
	end

	// Status/ID kept from the low byte
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			vector_q <= RST_IRQ_VECTOR;
		end else if (reg_write && addr_s == OFS_IRQ_VECTOR_BYTE) begin
			vector_q <= data_s[VECTOR_LSB +: VECTOR_W];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			trigger_q <= RST_EVENT_TRIGGER[COUNT_WIDTH-1:0];
		end else if (reg_write && addr_s == OFS_EVENT_COUNT_TRIGGER) begin
			trigger_q <= data_s[COUNT_WIDTH-1:0];
		end
	end

	// Read data, reserved bits as zero
	logic [DATA_W-1:0] reg_rdata;
	always_comb begin
		reg_rdata = '0;
		if (addr_s == OFS_IRQ_LEVEL_SELECT) begin
			reg_rdata[LEVEL_LSB +: LEVEL_W] = level_q;
		end else if (addr_s == OFS_IRQ_VECTOR_BYTE) begin
			reg_rdata[VECTOR_LSB +: VECTOR_W] = vector_q;
		end else if (addr_s == OFS_EVENT_COUNT_TRIGGER) begin
			reg_rdata[COUNT_WIDTH-1:0] = trigger_q;
		end
	end

	// ---------------------------------------------
	// Request condition
	// ---------------------------------------------
	logic enabled;
	logic count_equal;
	logic count_below;
	logic pending_q;

	assign enabled = trigger_q != TRIGGER_OFF[COUNT_WIDTH-1:0] && level_q != LEVEL_OFF;
	assign count_equal = event_count == trigger_q;
	assign count_below = event_count < trigger_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pending_q <= 1'b0;
		end else if (!enabled) begin
			pending_q <= 1'b0;
		end else if (count_equal) begin
			// Raised when the count reaches the trigger
			pending_q <= 1'b1;
		end else if (count_below) begin
			// Buffer reads drop the count below trigger
			pending_q <= 1'b0;
		end
	end

	// Drive only the programmed level line
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_oe <= '0;
			irq_n_out <= '0;
		end else begin
			irq_n_out <= '0;
			for (int i = 1; i <= 7; i++) begin
				irq_oe[i] <= pending_q && (level_q == i[LEVEL_W-1:0]);
			end
		end
	end

	// ---------------------------------------------
	// Acknowledge cycles
	// ---------------------------------------------
	logic ack_respond;
	logic ack_pass;

	// Any acknowledge width
	// Width lines ignored: one byte serves 8, 16 and 32 bit acknowledges
	iack_responder u_iack (
		.sys_clk(sys_clk),
		.rst(rst),
		.strobe_as(as_s),
		.strobe_ds(ds_s),
		.iack_cycle(iack_s),
		.iack_chain_in(iackin_s),
		.ack_level(addr_s[3:1]),
		.req_pending(pending_q),
		.req_level(level_q),
		.respond_q(ack_respond),
		.pass_q(ack_pass)
	);

	// Chain passed onward
	// Registered so the chain never glitches low
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			iackout_n <= 1'b1;
		end else begin
			iackout_n <= !ack_pass;
		end
	end

	// ---------------------------------------------
	// Data lines and answers
	// ---------------------------------------------
	logic reg_answer;
	assign reg_answer = reg_state_q == REG_ANSWER;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			data_out <= '0;
			data_oe <= '0;
		end else if (ack_respond) begin
			// Status/ID on the lowest eight lines
			data_out <= {{(DATA_W-VECTOR_W){1'b0}}, vector_q};
			data_oe <= {{(DATA_W-VECTOR_W){1'b0}}, {VECTOR_W{1'b1}}};
		end else if (reg_answer && reg_ok && !wr_s) begin
			data_out <= reg_rdata;
			data_oe <= '1;
		end else begin
			data_out <= '0;
			data_oe <= '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dtack_n_out <= 1'b1;
			dtack_oe <= 1'b0;
			berr_n_out <= 1'b1;
			berr_oe <= 1'b0;
		end else begin
			dtack_n_out <= 1'b0;
			dtack_oe <= ack_respond || (reg_answer && reg_ok);
			berr_n_out <= 1'b0;
			// Wide transfers to registers get a bus error
			berr_oe <= reg_answer && !reg_ok;
		end
	end
endmodule // event_count_bus_interrupter

// ===== verification/ecbi_assertions.sv
// Port checker for the interrupter.
// Assumes a master that holds its pins until the answer drops.
module ecbi_assertions #(
	parameter int COUNT_WIDTH = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Watched ports
	input wire logic [COUNT_WIDTH-1:0] event_count,
	input wire logic write_n,
	input wire logic iack_n,
	input wire logic [15:0] addr,
	input wire logic [15:0] data_in,
	input wire logic [15:0] data_out,
	input wire logic [15:0] data_oe,
	input wire logic dtack_n_out,
	input wire logic dtack_oe,
	input wire logic berr_n_out,
	input wire logic berr_oe,
	input wire logic iackout_n,
	input wire logic [7:1] irq_n_out,
	input wire logic [7:1] irq_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	import intr_pkg::*;
	logic [2:0] lvl_q;
	logic [7:0] vec_q;
	logic [COUNT_WIDTH-1:0] trg_q;
	// Shadow lags the design, so the hit check pauses while dtack stands
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lvl_q <= 3'h0;
			vec_q <= 8'h00;
			trg_q <= '0;
		end else if (dtack_oe && !write_n && iack_n) begin
			if (addr == OFS_IRQ_LEVEL_SELECT) lvl_q <= data_in[2:0];
			if (addr == OFS_IRQ_VECTOR_BYTE) vec_q <= data_in[7:0];
			if (addr == OFS_EVENT_COUNT_TRIGGER) trg_q <= data_in[COUNT_WIDTH-1:0];
		end
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_hit;
		(event_count == trg_q && trg_q != 0 && lvl_q != 0 && !dtack_oe) [*3];
	endsequence
	sequence s_low;
		(event_count < trg_q) [*3];
	endsequence
	chk_irq_on_hit: assert property (s_hit |-> irq_oe == 7'(1 << (lvl_q - 1)))
		else $error("request missing");
	chk_irq_low_off: assert property (s_low |-> irq_oe == 7'h00)
		else $error("request not dropped");
	chk_trig_zero_off: assert property ((trg_q == 0) [*3] |-> irq_oe == 7'h00)
		else $error("request with zero trigger");
	chk_level_zero_off: assert property ((lvl_q == 0) [*3] |-> irq_oe == 7'h00)
		else $error("request with zero level");
	chk_irq_one_level: assert property ($onehot0(irq_oe) && irq_n_out == 7'h00)
		else $error("bad request lines");
	chk_ack_status_byte: assert property (dtack_oe && !iack_n |->
		data_oe == 16'h00FF && data_out[7:0] == vec_q)
		else $error("bad status byte");
	chk_ack_own_level: assert property (dtack_oe && !iack_n |->
		irq_oe == 7'(1 << (addr[3:1] - 1)))
		else $error("answer at wrong level");
	chk_pass_quiet: assert property (!iackout_n |-> !dtack_oe && data_oe == 16'h0000)
		else $error("pass while answering");
	chk_berr_quiet: assert property (berr_oe |-> !dtack_oe && data_oe == 16'h0000)
		else $error("data with bus error");
	chk_answer_lines_low: assert property ((dtack_oe || berr_oe) |->
		!dtack_n_out && !berr_n_out)
		else $error("answer line not low");
endmodule // ecbi_assertions

bind event_count_bus_interrupter ecbi_assertions #(.COUNT_WIDTH(COUNT_WIDTH)) u_chk (
	.sys_clk(sys_clk), .rst(rst), .event_count(event_count), .write_n(write_n),
	.iack_n(iack_n), .addr(addr), .data_in(data_in), .data_out(data_out),
	.data_oe(data_oe), .dtack_n_out(dtack_n_out), .dtack_oe(dtack_oe),
	.berr_n_out(berr_n_out), .berr_oe(berr_oe), .iackout_n(iackout_n),
	.irq_n_out(irq_n_out), .irq_oe(irq_oe));

// ===== verification/bus_master_model.sv
// Backplane master acting as interrupt handler.
// Assumes registered answers from the interrupter on sys_clk.
module bus_master_model (
	// Clock
	input wire logic sys_clk,
	// Cycle pins
	output logic as_n,
	output logic [1:0] ds_n,
	output logic write_n,
	output logic lword_n,
	output logic iack_n,
	output logic iackin_n,
	output logic [15:0] addr,
	// Data wire and answers
	output logic [15:0] data_in,
	input wire logic [15:0] data_out,
	input wire logic [15:0] data_oe,
	input wire logic dtack_oe,
	input wire logic berr_oe,
	input wire logic iackout_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] md = 16'h0000;
	// Released lines show the inverse of their last value
	assign data_in = (data_out & data_oe) | (md & ~data_oe);
	initial begin
		as_n = 1'b1;
		ds_n = 2'h3;
		{write_n, lword_n, iack_n, iackin_n} = 4'hF;
		addr = 16'h0000;
	end
	// Result r: 0 none, 1 dtack, 2 bus error, 3 passed on
	task automatic cyc(input bit ia, w, lw, input logic [1:0] ds,
		input logic [15:0] a, d, output logic [15:0] q, output int r);
		r = 0;
		@(posedge sys_clk);
		#1;
		md = w ? d : ~md;
		addr = a;
		write_n = !w;
		lword_n = !lw;
		iack_n = !ia;
		iackin_n = !ia;
		as_n = 1'b0;
		ds_n = ds;
		for (int n = 0; n < 30 && r == 0; n++) begin
			@(posedge sys_clk);
			#1;
			if (dtack_oe) r = 1;
			else if (berr_oe) r = 2;
			else if (!iackout_n) r = 3;
		end
		q = data_in;
		ds_n = 2'h3;
		for (int n = 0; n < 30 && (dtack_oe || berr_oe); n++) begin
			@(posedge sys_clk);
			#1;
		end
		md = ~md;
		as_n = 1'b1;
		{write_n, lword_n, iack_n, iackin_n} = 4'hF;
		repeat (6) @(posedge sys_clk);
	endtask
endmodule // bus_master_model

// ===== verification/tb_top.sv
// Self-checking bench: master model, count stimulus, reference model.
// Assumes the checker is bound to the design.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import intr_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] event_count = 16'h0000;
	logic addr_hit = 1'b1;
	logic as_n, write_n, lword_n, iack_n, iackin_n, dtack_n_out, dtack_oe;
	logic berr_n_out, berr_oe, iackout_n;
	logic [1:0] ds_n;
	logic [15:0] addr, data_in, data_out, data_oe, q;
	logic [7:1] irq_n_out, irq_oe;
	int errors = 0;
	int n_compared = 0;
	int lvl, vec, trg, pend, r;
	always #2 sys_clk = ~sys_clk;
	event_count_bus_interrupter DUT (.sys_clk, .rst, .event_count, .addr_hit, .as_n,
		.ds_n, .write_n, .lword_n, .iack_n, .iackin_n, .addr, .data_in, .data_out,
		.data_oe, .dtack_n_out, .dtack_oe, .berr_n_out, .berr_oe, .iackout_n,
		.irq_n_out, .irq_oe);
	bus_master_model m (.sys_clk, .as_n, .ds_n, .write_n, .lword_n, .iack_n,
		.iackin_n, .addr, .data_in, .data_out, .data_oe, .dtack_oe, .berr_oe,
		.iackout_n);
	// ----
	// Compare and cycle tasks
	// ----
	task automatic cmp(input string nm, input logic [15:0] e, g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cmpr(input string nm, input int e, g);
		n_compared++;
		if (g != e) begin
			errors++;
			$display("wrong value %s exp %0d got %0d", nm, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, d);
		m.cyc(0, 1, 0, 2'h0, a, d, q, r);
		cmpr("write answer", 1, r);
	endtask
	task automatic rd(input logic [15:0] a, e);
		m.cyc(0, 0, 0, 2'h0, a, 16'h0000, q, r);
		cmpr("read answer", 1, r);
		cmp("read data", e, q);
	endtask
	// New count, then the request lines against the model
	task automatic ev(input int c);
		@(posedge sys_clk);
		#1;
		event_count = 16'(c);
		if (trg == 0 || lvl == 0) pend = 0;
		else if (c == trg) pend = 1;
		else if (c < trg) pend = 0;
		repeat (4) @(posedge sys_clk);
		#1;
		cmp("irq_oe", pend ? 16'(1 << (lvl - 1)) : 16'h0000, {9'h000, irq_oe});
	endtask
	task automatic iak(input int l, input bit lw, input logic [1:0] ds);
		m.cyc(1, 0, lw, ds, 16'(l << 1), 16'h0000, q, r);
		cmpr("ack answer", (pend && l == lvl) ? 1 : 3, r);
		if (r == 1) cmp("status id", 16'(vec), {8'h00, q[7:0]});
	endtask
	task automatic end_of_test;
		if (errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ----
	// Scenarios
	// ----
	initial begin
		void'($urandom(32'h5D05E1B6));
		{lvl, vec, trg, pend} = '0;
		repeat (5) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge sys_clk);
		rd(OFS_IRQ_LEVEL_SELECT, 16'h0000);
		rd(OFS_IRQ_VECTOR_BYTE, 16'h0000);
		rd(OFS_EVENT_COUNT_TRIGGER, 16'h0000);
		ev(0);
		m.cyc(0, 1, 1, 2'h0, OFS_EVENT_COUNT_TRIGGER, 16'h0003, q, r);
		cmpr("d32 answer", 2, r);
		rd(OFS_EVENT_COUNT_TRIGGER, 16'h0000);
		m.cyc(0, 0, 0, 2'h0, 16'h100E, 16'h0000, q, r);
		cmpr("unmapped answer", 0, r);
		// Board not selected: mapped offset stays silent
		#1;
		addr_hit = 1'b0;
		m.cyc(0, 0, 0, 2'h0, OFS_IRQ_VECTOR_BYTE, 16'h0000, q, r);
		cmpr("foreign answer", 0, r);
		#1;
		addr_hit = 1'b1;
		for (int k = 0; k < 3; k++) begin
			ev(0);
			lvl = $urandom_range(7, 1);
			vec = $urandom_range(255, 0);
			trg = $urandom_range(5, 2);
			wr(OFS_IRQ_LEVEL_SELECT, 16'hFFF8 | 16'(lvl));
			wr(OFS_IRQ_VECTOR_BYTE, 16'hAB00 | 16'(vec));
			wr(OFS_EVENT_COUNT_TRIGGER, 16'(trg));
			rd(OFS_IRQ_LEVEL_SELECT, 16'(lvl));
			rd(OFS_IRQ_VECTOR_BYTE, 16'(vec));
			for (int c = 0; c <= trg + 1; c++) ev(c);
			for (int l = 1; l < 8; l++) iak(l, l % 3 == 0, (l % 3 == 1) ? 2'h2 : 2'h0);
			// Buffer reads lower the count
			ev(trg - 1);
			repeat (6) ev($urandom_range(trg + 2, 0));
		end
		ev(0);
		ev(trg);
		wr(OFS_IRQ_LEVEL_SELECT, 16'h0000);
		lvl = 0;
		ev(trg);
		wr(OFS_IRQ_LEVEL_SELECT, 16'h0004);
		lvl = 4;
		wr(OFS_EVENT_COUNT_TRIGGER, 16'h0000);
		trg = 0;
		ev(0);
		end_of_test();
	end
	initial begin
		#100000;
		errors++;
		end_of_test();
	end
endmodule // tb_top
